// >>> i3c_target_consts.svh
// Notes on behaviour
// - Event enable and disable taken in broadcast and direct form, codes 0x00/0x01 and 0x80/0x81.
// - Joins broadcast dynamic address assignment, code 0x07, and takes the assigned address.
// - Static-to-dynamic address command, code 0x87, honoured once until reset.
// - Set-new-dynamic-address, code 0x88, replaces the current address without reset.
// - Device characteristics query, code 0x8F, returns the fixed characteristics byte.
// - Bus characteristics query, code 0x8E, returns the fixed bus byte.
// - Unsupported commands, such as 0x8B and 0x20, cause no action.
// - First private write byte is a dummy bit then 7-bit pointer, MSB first.
// - Data moves in 8-bit units, most significant bit first.
// - Back-to-back reads keep incrementing the pointer until a new address is set.
// - Private writes carry the address first; later bytes go to incrementing addresses.
// - Transactions work with or without the broadcast 7E header in front.
// - Protocol errors recover by one method only: ignore the bus until STOP.
// - After an error, in-band interrupts are withheld until START or STOP.
// - In-band interrupts disabled at reset, enabled by event-enable with its enable bit.
// - Status query returns two bytes: 0x00, then the four interrupt flags in the low bits.
`ifndef I3C_TARGET_CONSTS_SVH
`define I3C_TARGET_CONSTS_SVH

`define CCC_ENEC_B 8'h00
`define CCC_DISEC_B 8'h01
`define CCC_RSTDAA_B 8'h06
`define CCC_ENTDAA 8'h07
`define CCC_ENEC_D 8'h80
`define CCC_DISEC_D 8'h81
`define CCC_RSTDAA_D 8'h86
`define CCC_SETDASA 8'h87
`define CCC_SETNEWDA 8'h88
`define CCC_GETPID 8'h8D
`define CCC_GETBCR 8'h8E
`define CCC_GETDCR 8'h8F
`define CCC_GETSTATUS 8'h90

`define BCAST_ADDR 7'h7E
`define STATIC_ADDR_BASE 7'h46
`define DCR_VALUE 8'h62
`define BCR_VALUE 8'h06
`define ENINT_BIT 0

`define PID_LAST_IDX 3'h5
`define STATUS_LAST_IDX 3'h1
`define DAA_BITS 7'h40
`define BYTE_LAST_BIT 4'h7
`define BYTE_T_BIT 4'h8
`define BYTE_NEXT 4'h9

`define INT_EN_RST 1'b0
`define PTR_RST 7'h00
`define DYN_ADDR_RST 7'h00

`endif

// >>> i3c_target_pkg.sv
package i3c_target_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WBYTE,
    ST_RBYTE,
    ST_DAA,
    ST_DAA_ADDR,
    ST_SKIP,
    ST_ERR
  } state_e;

  typedef enum logic [2:0] {
    M_PRIV_W,
    M_PRIV_R,
    M_BCAST,
    M_DIR_W,
    M_DIR_R,
    M_DAA,
    M_DAA_DONE
  } mode_e;

endpackage

// >>> i3c_target.sv
`timescale 1ns/100ps
`default_nettype none
`include "i3c_target_consts.svh"

module i3c_target #(
  // Provisional ID value is arbitrary
  parameter logic [47:0] PROV_ID = 48'h0123_4567_89AB
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic LINK_CLK_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic ADDR_SEL_I,
  input wire logic [3:0] STATUS_I,
  output logic REG_WR_O,
  output logic REG_RD_O,
  output logic [6:0] REG_ADDR_O,
  output logic [7:0] REG_WDATA_O,
  input wire logic [7:0] REG_RDATA_I,
  output logic EVT_EN_O,
  output logic IBI_ALLOWED_O,
  output logic DYN_ADDR_VALID_O
);
  import i3c_target_pkg::*;

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic rst_meta, link_rst;
  logic scl_meta, scl_s, scl_p;
  logic sda_meta, sda_s, sda_p;
  logic sel_meta, sel_s;
  logic ack_meta, ack_s;
  logic [3:0] stat_meta, stat_s;
  logic req_meta, req_s, req_p;
  logic [2:0] flag_meta, flag_s;

  logic int_en_reg, ibi_hold_reg, dyn_valid_reg, req_tgl_reg, ack_tgl_reg;
  logic [3:0] status_reg;

  always_ff @(posedge LINK_CLK_I)
  begin
    rst_meta <= RST_I;
    link_rst <= rst_meta;
    scl_meta <= SCL_I;
    scl_s <= scl_meta;
    scl_p <= scl_s;
    sda_meta <= SDA_I;
    sda_s <= sda_meta;
    sda_p <= sda_s;
    sel_meta <= ADDR_SEL_I;
    sel_s <= sel_meta;
    ack_meta <= ack_tgl_reg;
    ack_s <= ack_meta;
    stat_meta <= status_reg;
    stat_s <= stat_meta;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    req_meta <= req_tgl_reg;
    req_s <= req_meta;
    req_p <= req_s;
    flag_meta <= {int_en_reg, ibi_hold_reg, dyn_valid_reg};
    flag_s <= flag_meta;
  end

  // ------------------------------------------------------------
  // Link bus conditions
  // ------------------------------------------------------------
  logic start_det, stop_det, scl_rise, scl_fall, acc_done;
  logic [7:0] byte_in;
  logic [6:0] static_addr;

  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign static_addr = `STATIC_ADDR_BASE | {6'h00, sel_s};
  assign acc_done = (ack_s == req_tgl_reg);

  // ------------------------------------------------------------
  // Link state
  // ------------------------------------------------------------
  state_e state_reg, state_next;
  mode_e mode_reg, mode_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] idx_reg, idx_next;
  logic [7:0] sh_reg, sh_next;
  logic [63:0] daa_sh_reg, daa_sh_next;
  logic [6:0] daa_cnt_reg, daa_cnt_next;
  logic [7:0] ccc_reg, ccc_next;
  logic ccc_on_reg, ccc_on_next;
  logic [6:0] dyn_addr_reg, dyn_addr_next;
  logic dyn_valid_next, dasa_used_reg, dasa_used_next;
  logic int_en_next, ibi_hold_next, last_reg, last_next;
  logic [6:0] ptr_reg, ptr_next;
  logic req_tgl_next, acc_we_reg, acc_we_next;
  logic [6:0] acc_addr_reg, acc_addr_next;
  logic [7:0] acc_wdata_reg, acc_wdata_next, rdata_reg;
  logic sda_o_reg, sda_o_next, sda_oe_reg, sda_oe_next;
  logic hit, err, dir_w_ok, dir_r_ok;
  logic [7:0] rb_byte;
  logic rb_last;
  logic [47:0] pid_sh;

  assign byte_in = {sh_reg[6:0], sda_s};

  // Read source
  always_comb
  begin
    pid_sh = PROV_ID << {idx_reg, 3'b000};
    rb_byte = 8'h00;
    rb_last = 1'b1;
    if (mode_reg == M_PRIV_R)
    begin
      rb_byte = acc_done ? rdata_reg : 8'hFF;
      rb_last = 1'b0;
    end
    else if (ccc_reg == `CCC_GETBCR)
      rb_byte = `BCR_VALUE;
    else if (ccc_reg == `CCC_GETDCR)
      rb_byte = `DCR_VALUE;
    else if (ccc_reg == `CCC_GETSTATUS)
    begin
      rb_byte = (idx_reg == 3'h0) ? 8'h00 : {4'h0, stat_s};
      rb_last = (idx_reg == `STATUS_LAST_IDX);
    end
    else if (ccc_reg == `CCC_GETPID)
    begin
      rb_byte = pid_sh[47:40];
      rb_last = (idx_reg == `PID_LAST_IDX);
    end
  end

  assign dir_w_ok = (ccc_reg == `CCC_ENEC_D) || (ccc_reg == `CCC_DISEC_D) ||
                    (ccc_reg == `CCC_SETNEWDA) || (ccc_reg == `CCC_RSTDAA_D);
  assign dir_r_ok = (ccc_reg == `CCC_GETPID) || (ccc_reg == `CCC_GETBCR) ||
                    (ccc_reg == `CCC_GETDCR) || (ccc_reg == `CCC_GETSTATUS);

  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    sh_next = sh_reg;
    daa_sh_next = daa_sh_reg;
    daa_cnt_next = daa_cnt_reg;
    ccc_next = ccc_reg;
    ccc_on_next = ccc_on_reg;
    dyn_addr_next = dyn_addr_reg;
    dyn_valid_next = dyn_valid_reg;
    dasa_used_next = dasa_used_reg;
    int_en_next = int_en_reg;
    ibi_hold_next = ibi_hold_reg;
    last_next = last_reg;
    ptr_next = ptr_reg;
    req_tgl_next = req_tgl_reg;
    acc_we_next = acc_we_reg;
    acc_addr_next = acc_addr_reg;
    acc_wdata_next = acc_wdata_reg;
    sda_o_next = sda_o_reg;
    sda_oe_next = sda_oe_reg;
    hit = 1'b0;
    err = 1'b0;
    if (start_det)
    begin
      ibi_hold_next = 1'b0;
      sda_oe_next = 1'b0;
      if (state_reg != ST_ERR)
      begin
        state_next = ST_ADDR;
        cnt_next = 4'h0;
      end
    end
    else if (stop_det)
    begin
      ibi_hold_next = 1'b0;
      sda_oe_next = 1'b0;
      state_next = ST_IDLE;
      ccc_on_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_ADDR:
          if (scl_rise)
          begin
            sh_next = byte_in;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == `BYTE_LAST_BIT)
            begin
              cnt_next = 4'h0;
              idx_next = 3'h0;
              if (byte_in[7:1] == `BCAST_ADDR)
              begin
                if (!byte_in[0])
                begin
                  hit = 1'b1;
                  mode_next = M_BCAST;
                end
                else if (ccc_on_reg && ccc_reg == `CCC_ENTDAA)
                begin
                  hit = !dyn_valid_reg;
                  mode_next = M_DAA;
                end
                else
                  err = 1'b1;
              end
              else if (ccc_on_reg && ccc_reg[7])
              begin
                if (dyn_valid_reg && byte_in[7:1] == dyn_addr_reg)
                begin
                  hit = byte_in[0] ? dir_r_ok : dir_w_ok;
                  mode_next = byte_in[0] ? M_DIR_R : M_DIR_W;
                  if (!byte_in[0] && ccc_reg == `CCC_RSTDAA_D)
                    dyn_valid_next = 1'b0;
                end
                else if (!dyn_valid_reg && !dasa_used_reg && !byte_in[0] &&
                         ccc_reg == `CCC_SETDASA && byte_in[7:1] == static_addr)
                begin
                  hit = 1'b1;
                  mode_next = M_DIR_W;
                end
              end
              else if (dyn_valid_reg && byte_in[7:1] == dyn_addr_reg)
              begin
                hit = 1'b1;
                mode_next = byte_in[0] ? M_PRIV_R : M_PRIV_W;
                if (byte_in[0])
                begin
                  req_tgl_next = ~req_tgl_reg;
                  acc_we_next = 1'b0;
                  acc_addr_next = ptr_reg;
                end
              end
              if (err)
              begin
                state_next = ST_ERR;
                ibi_hold_next = 1'b1;
              end
              else
                state_next = hit ? ST_ACK : ST_SKIP;
            end
          end
        ST_ACK:
          if (scl_fall && cnt_reg == 4'h0)
          begin
            sda_o_next = 1'b0;
            sda_oe_next = 1'b1;
            cnt_next = 4'h1;
          end
          else if (scl_rise && cnt_reg == 4'h1)
            cnt_next = 4'h2;
          else if (scl_fall && cnt_reg == 4'h2)
          begin
            cnt_next = 4'h0;
            sda_oe_next = 1'b0;
            state_next = ST_WBYTE;
            if (mode_reg == M_PRIV_R || mode_reg == M_DIR_R)
            begin
              state_next = ST_RBYTE;
              sda_o_next = rb_byte[7];
              sda_oe_next = 1'b1;
              sh_next = {rb_byte[6:0], 1'b0};
              last_next = rb_last;
            end
            else if (mode_reg == M_DAA)
            begin
              state_next = ST_DAA;
              daa_sh_next = {PROV_ID[46:0], `BCR_VALUE, `DCR_VALUE, 1'b0};
              sda_o_next = 1'b0;
              sda_oe_next = ~PROV_ID[47];
              daa_cnt_next = 7'h00;
            end
            else if (mode_reg == M_DAA_DONE)
              state_next = ST_SKIP;
          end
        ST_RBYTE:
          if (scl_rise)
          begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == `BYTE_T_BIT)
            begin
              idx_next = idx_reg + 3'h1;
              if (mode_reg == M_PRIV_R)
                ptr_next = ptr_reg + 7'h01;
              if (last_reg || (!sda_oe_reg && !sda_s))
                state_next = ST_SKIP;
              else if (mode_reg == M_PRIV_R)
              begin
                req_tgl_next = ~req_tgl_reg;
                acc_we_next = 1'b0;
                acc_addr_next = ptr_reg + 7'h01;
              end
            end
          end
          else if (scl_fall)
          begin
            if (cnt_reg < `BYTE_T_BIT)
            begin
              sda_o_next = sh_reg[7];
              sh_next = {sh_reg[6:0], 1'b0};
            end
            else if (cnt_reg == `BYTE_T_BIT)
            begin
              sda_o_next = 1'b0;
              sda_oe_next = last_reg;
            end
            else
            begin
              cnt_next = 4'h0;
              sda_o_next = rb_byte[7];
              sda_oe_next = 1'b1;
              sh_next = {rb_byte[6:0], 1'b0};
              last_next = rb_last;
            end
          end
        ST_WBYTE:
          if (scl_rise)
          begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg < `BYTE_T_BIT)
              sh_next = byte_in;
            else if (!(^{sh_reg, sda_s}))
            begin
              state_next = ST_ERR;
              ibi_hold_next = 1'b1;
            end
            else
            begin
              cnt_next = 4'h0;
              idx_next = (idx_reg == 3'h7) ? 3'h7 : idx_reg + 3'h1;
              if (mode_reg == M_BCAST && idx_reg == 3'h0)
              begin
                ccc_next = sh_reg;
                ccc_on_next = 1'b1;
                if (sh_reg == `CCC_RSTDAA_B)
                  dyn_valid_next = 1'b0;
                if (sh_reg != `CCC_ENEC_B && sh_reg != `CCC_DISEC_B)
                  state_next = ST_SKIP;
              end
              else if (mode_reg == M_PRIV_W)
              begin
                if (idx_reg == 3'h0)
                  ptr_next = sh_reg[6:0];
                else
                begin
                  req_tgl_next = ~req_tgl_reg;
                  acc_we_next = 1'b1;
                  acc_addr_next = ptr_reg;
                  acc_wdata_next = sh_reg;
                  ptr_next = ptr_reg + 7'h01;
                end
              end
              else if (ccc_reg == `CCC_ENEC_B || ccc_reg == `CCC_ENEC_D)
              begin
                if (sh_reg[`ENINT_BIT])
                  int_en_next = 1'b1;
              end
              else if (ccc_reg == `CCC_DISEC_B || ccc_reg == `CCC_DISEC_D)
              begin
                if (sh_reg[`ENINT_BIT])
                  int_en_next = 1'b0;
              end
              else if (ccc_reg == `CCC_SETDASA)
              begin
                dyn_addr_next = sh_reg[7:1];
                dyn_valid_next = 1'b1;
                dasa_used_next = 1'b1;
                state_next = ST_SKIP;
              end
              else if (ccc_reg == `CCC_SETNEWDA)
              begin
                dyn_addr_next = sh_reg[7:1];
                state_next = ST_SKIP;
              end
              else
                state_next = ST_SKIP;
            end
          end
        ST_DAA:
          if (scl_rise)
          begin
            daa_cnt_next = daa_cnt_reg + 7'h01;
            if (!sda_oe_reg && !sda_s)
              state_next = ST_SKIP;
          end
          else if (scl_fall)
          begin
            if (daa_cnt_reg < `DAA_BITS)
            begin
              sda_oe_next = ~daa_sh_reg[63];
              daa_sh_next = {daa_sh_reg[62:0], 1'b0};
            end
            else
            begin
              sda_oe_next = 1'b0;
              state_next = ST_DAA_ADDR;
              cnt_next = 4'h0;
            end
          end
        ST_DAA_ADDR:
          if (scl_rise)
          begin
            sh_next = byte_in;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == `BYTE_LAST_BIT)
            begin
              cnt_next = 4'h0;
              state_next = ST_SKIP;
              if (^byte_in)
              begin
                dyn_addr_next = byte_in[7:1];
                dyn_valid_next = 1'b1;
                mode_next = M_DAA_DONE;
                state_next = ST_ACK;
              end
            end
          end
        ST_SKIP:
          if (scl_fall)
            sda_oe_next = 1'b0;
        default:
          state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge LINK_CLK_I)
  begin
    if (link_rst)
    begin
      state_reg <= ST_IDLE;
      mode_reg <= M_PRIV_W;
      cnt_reg <= 4'h0;
      idx_reg <= 3'h0;
      sh_reg <= 8'h00;
      daa_sh_reg <= 64'h0;
      daa_cnt_reg <= 7'h00;
      ccc_reg <= 8'h00;
      ccc_on_reg <= 1'b0;
      dyn_addr_reg <= `DYN_ADDR_RST;
      dyn_valid_reg <= 1'b0;
      dasa_used_reg <= 1'b0;
      int_en_reg <= `INT_EN_RST;
      ibi_hold_reg <= 1'b0;
      last_reg <= 1'b0;
      ptr_reg <= `PTR_RST;
      req_tgl_reg <= 1'b0;
      acc_we_reg <= 1'b0;
      acc_addr_reg <= 7'h00;
      acc_wdata_reg <= 8'h00;
      sda_o_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      sh_reg <= sh_next;
      daa_sh_reg <= daa_sh_next;
      daa_cnt_reg <= daa_cnt_next;
      ccc_reg <= ccc_next;
      ccc_on_reg <= ccc_on_next;
      dyn_addr_reg <= dyn_addr_next;
      dyn_valid_reg <= dyn_valid_next;
      dasa_used_reg <= dasa_used_next;
      int_en_reg <= int_en_next;
      ibi_hold_reg <= ibi_hold_next;
      last_reg <= last_next;
      ptr_reg <= ptr_next;
      req_tgl_reg <= req_tgl_next;
      acc_we_reg <= acc_we_next;
      acc_addr_reg <= acc_addr_next;
      acc_wdata_reg <= acc_wdata_next;
      sda_o_reg <= sda_o_next;
      sda_oe_reg <= sda_oe_next;
    end
  end

  assign SDA_O = sda_o_reg;
  assign SDA_OE_O = sda_oe_reg;

  // ------------------------------------------------------------
  // System side register access
  // ------------------------------------------------------------
  logic wr_next, rd_next, rd_pend_reg, rd_pend_next, ack_tgl_next;
  logic [6:0] addr_next;
  logic [7:0] wdata_next, rdata_next;
  logic evt_next, ibi_next, dv_next;

  always_comb
  begin
    wr_next = 1'b0;
    rd_next = 1'b0;
    addr_next = REG_ADDR_O;
    wdata_next = REG_WDATA_O;
    rdata_next = rdata_reg;
    ack_tgl_next = ack_tgl_reg;
    rd_pend_next = REG_RD_O;
    if (req_s ^ req_p)
    begin
      addr_next = acc_addr_reg;
      if (acc_we_reg)
      begin
        wr_next = 1'b1;
        wdata_next = acc_wdata_reg;
        ack_tgl_next = ~ack_tgl_reg;
      end
      else
        rd_next = 1'b1;
    end
    if (rd_pend_reg)
    begin
      rdata_next = REG_RDATA_I;
      ack_tgl_next = ~ack_tgl_reg;
    end
    evt_next = flag_s[2];
    ibi_next = flag_s[2] & ~flag_s[1] & flag_s[0];
    dv_next = flag_s[0];
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      REG_WR_O <= 1'b0;
      REG_RD_O <= 1'b0;
      REG_ADDR_O <= 7'h00;
      REG_WDATA_O <= 8'h00;
      rdata_reg <= 8'h00;
      ack_tgl_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      status_reg <= 4'h0;
      EVT_EN_O <= 1'b0;
      IBI_ALLOWED_O <= 1'b0;
      DYN_ADDR_VALID_O <= 1'b0;
    end
    else
    begin
      REG_WR_O <= wr_next;
      REG_RD_O <= rd_next;
      REG_ADDR_O <= addr_next;
      REG_WDATA_O <= wdata_next;
      rdata_reg <= rdata_next;
      ack_tgl_reg <= ack_tgl_next;
      rd_pend_reg <= rd_pend_next;
      status_reg <= STATUS_I;
      EVT_EN_O <= evt_next;
      IBI_ALLOWED_O <= ibi_next;
      DYN_ADDR_VALID_O <= dv_next;
    end
  end

endmodule
`default_nettype wire

// >>> i3c_target_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// Port checker
// ---------------------------------------------
module i3c_target_checker (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic LINK_CLK_I,
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic REG_WR_O,
  input wire logic REG_RD_O,
  input wire logic [6:0] REG_ADDR_O,
  input wire logic [7:0] REG_WDATA_O,
  input wire logic EVT_EN_O,
  input wire logic IBI_ALLOWED_O,
  input wire logic DYN_ADDR_VALID_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  sequence s_rst_held;
    RST_I [*6];
  endsequence
  sequence s_quiet;
    !EVT_EN_O && !DYN_ADDR_VALID_O && !IBI_ALLOWED_O && !SDA_OE_O;
  endsequence
  property p_rst_quiet;
    disable iff (1'b0) s_rst_held |-> s_quiet;
  endproperty
  property p_wr_gap;
    REG_WR_O |=> !REG_WR_O [*8];
  endproperty
  property p_rd_gap;
    REG_RD_O |=> !REG_RD_O [*8];
  endproperty
  property p_no_overlap;
    REG_WR_O |-> !REG_RD_O;
  endproperty
  property p_wr_hold;
    REG_WR_O |=> ($stable(REG_ADDR_O) && $stable(REG_WDATA_O)) [*4];
  endproperty
  property p_ibi_rise;
    $rose(IBI_ALLOWED_O) |-> EVT_EN_O && DYN_ADDR_VALID_O;
  endproperty
  property p_ibi_fall;
    $fell(EVT_EN_O) |-> ##[0:2] !IBI_ALLOWED_O;
  endproperty
  property p_sda_scl_low;
    @(posedge LINK_CLK_I) $changed(SDA_OE_O) || (SDA_OE_O && $changed(SDA_O)) |-> !SCL_I;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("active in reset");
  a_wr_gap: assert property (p_wr_gap) else $error("write strobe too long");
  a_rd_gap: assert property (p_rd_gap) else $error("read strobe too long");
  a_no_overlap: assert property (p_no_overlap) else $error("read and write");
  a_wr_hold: assert property (p_wr_hold) else $error("write bus moved");
  a_ibi_rise: assert property (p_ibi_rise) else $error("ibi without enable");
  a_ibi_fall: assert property (p_ibi_fall) else $error("ibi kept");
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved");
endmodule
bind i3c_target i3c_target_checker u_chk (.CLK_SYS_I, .RST_I, .LINK_CLK_I, .SCL_I, .SDA_O,
  .SDA_OE_O, .REG_WR_O, .REG_RD_O, .REG_ADDR_O, .REG_WDATA_O, .EVT_EN_O, .IBI_ALLOWED_O,
  .DYN_ADDR_VALID_O);
`default_nettype wire

// >>> i3c_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------
// Bus controller model
// ---------------------------------------------
module i3c_ctl_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Start or repeated start, SCL left low
  task automatic start();
    wt(8);
    sda_o = 1'b1;
    wt(15);
    scl_o = 1'b1;
    wt(15);
    sda_o = 1'b0;
    wt(15);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    wt(8);
    sda_o = 1'b0;
    wt(15);
    scl_o = 1'b1;
    wt(15);
    sda_o = 1'b1;
    wt(30);
  endtask
  // Bits MSB first; 1 releases the line
  task automatic io(input logic [63:0] v, input int n, output logic [63:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      wt(8);
      sda_o = v[i];
      wt(22);
      scl_o = 1'b1;
      wt(15);
      r[i] = sda_i;
      wt(15);
      scl_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> i3c_target_ccc_and_sdr_access_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module i3c_target_ccc_and_sdr_access_tb;
  localparam logic [47:0] PID = 48'h0A1B_2C3D_4E5F; // Arbitrary value
  int n_checks = 0;
  int miscompares = 0;
  int cyc = 0;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] rdata = 8'h00;
  logic [3:0] status = 4'hA;
  logic [6:0] da;
  logic scl;
  logic host_sda;
  logic sda_o;
  logic sda_oe;
  logic reg_wr;
  logic reg_rd;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic evt_en;
  logic ibi_ok;
  logic da_valid;
  logic [14:0] wq[$];
  wire logic sda_bus;
  assign sda_bus = host_sda & (sda_oe ? sda_o : 1'b1);
  initial
  begin
    forever #25 clk = ~clk;
  end
  initial
  begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  i3c_target #(.PROV_ID(PID)) uut (.CLK_SYS_I(clk), .RST_I(rst), .LINK_CLK_I(link_clk),
    .SCL_I(scl), .SDA_I(sda_bus), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDR_SEL_I(1'b0),
    .STATUS_I(status), .REG_WR_O(reg_wr), .REG_RD_O(reg_rd), .REG_ADDR_O(reg_addr),
    .REG_WDATA_O(reg_wdata), .REG_RDATA_I(rdata), .EVT_EN_O(evt_en),
    .IBI_ALLOWED_O(ibi_ok), .DYN_ADDR_VALID_O(da_valid));
  i3c_ctl_model ctl (.clk_i(clk), .sda_i(sda_bus), .scl_o(scl), .sda_o(host_sda));
  always @(negedge clk)
  begin
    if (reg_wr === 1'b1)
      wq.push_back({reg_addr, reg_wdata});
    cyc++;
    if (cyc == 100000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  always @(negedge clk)
  begin
    rdata <= {1'b1, reg_addr} ^ 8'h5A;
  end
  function automatic logic [7:0] fx(input logic [6:0] a);
    return {1'b1, a} ^ 8'h5A;
  endfunction
  // ---------------------------------------------
  // Bus helpers and scenarios
  // ---------------------------------------------
  task automatic send(input logic [7:0] a, output logic ack);
    logic [63:0] r;
    ctl.io(64'({a, 1'b1}), 9, r);
    ack = ~r[0];
  endtask
  task automatic wr(input logic [7:0] d);
    logic [63:0] r;
    ctl.io(64'({d, ~^d}), 9, r);
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic [63:0] r;
    ctl.io(64'({8'hFF, ~last}), 9, r);
    d = r[8:1];
  endtask
  task automatic dset(input logic [7:0] c, input logic [6:0] a, input logic [7:0] d,
    output logic ack);
    logic k;
    ctl.start();
    send(8'hFC, k);
    wr(c);
    ctl.start();
    send({a, 1'b0}, ack);
    if (ack)
      wr(d);
    ctl.stop();
  endtask
  task automatic dget(input logic [7:0] c, input int n, output logic [15:0] g);
    logic k;
    logic [7:0] b;
    g = '0;
    ctl.start();
    send(8'hFC, k);
    wr(c);
    ctl.start();
    send({da, 1'b1}, k);
    for (int i = 0; i < n; i++)
    begin
      rd(i == n - 1, b);
      g = {g[7:0], b};
    end
    ctl.stop();
  endtask
  task automatic bset(input logic [7:0] c, input logic [7:0] d);
    logic k;
    ctl.start();
    send(8'hFC, k);
    wr(c);
    wr(d);
    ctl.stop();
  endtask
  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  task automatic t_dasa;
    logic k;
    dset(8'h87, 7'h46, 8'h42, k);
    `CHK("dasa", 2'b11, {k, da_valid})
    dset(8'h87, 7'h46, 8'h44, k);
    dset(8'h80, 7'h22, 8'h00, k);
    `CHK("dasa again", 1'b0, k)
    dset(8'h80, 7'h21, 8'h00, k);
    `CHK("dasa kept", 1'b1, k)
  endtask
  task automatic t_daa;
    logic k;
    logic [63:0] r;
    ctl.start();
    send(8'hFC, k);
    wr(8'h07);
    ctl.start();
    send(8'hFD, k);
    `CHK("daa ack", 1'b1, k)
    ctl.io('1, 64, r);
    `CHK("daa id", {PID, 8'h06, 8'h62}, r)
    ctl.io(64'({7'h2A, ~^7'h2A, 1'b1}), 9, r);
    ctl.stop();
    `CHK("daa addr", 2'b01, {r[0], da_valid})
  endtask
  task automatic t_wr;
    logic k;
    ctl.start();
    send(8'hFC, k);
    ctl.start();
    send({da, 1'b0}, k);
    wr(8'hFF);
    wr(8'hC3);
    wr(8'h3C);
    ctl.stop();
    `CHK("wr count", 2, wq.size())
    `CHK("wr first", {7'h7F, 8'hC3}, wq.pop_front())
    `CHK("wr wrap", {7'h00, 8'h3C}, wq.pop_front())
  endtask
  task automatic t_rd;
    logic k;
    logic [7:0] b;
    ctl.start();
    send({da, 1'b0}, k);
    wr(8'h10);
    ctl.start();
    send({da, 1'b1}, k);
    rd(1'b0, b);
    `CHK("rd first", fx(7'h10), b)
    rd(1'b1, b);
    `CHK("rd inc", fx(7'h11), b)
    ctl.stop();
    ctl.start();
    send({da, 1'b1}, k);
    rd(1'b1, b);
    ctl.stop();
    `CHK("rd next", fx(7'h12), b)
    `CHK("no wr", 0, wq.size())
  endtask
  task automatic t_ccc;
    logic k;
    logic [15:0] g;
    dget(8'h8F, 1, g);
    `CHK("dcr", 16'h0062, g)
    dget(8'h8E, 1, g);
    `CHK("bcr", 16'h0006, g)
    dget(8'h8D, 2, g);
    `CHK("pid", PID[47:32], g)
    dget(8'h90, 2, g);
    `CHK("status", {12'h000, status}, g)
    dset(8'h80, da, 8'h01, k);
    `CHK("en", 2'b11, {evt_en, ibi_ok})
    dset(8'h8B, da, 8'h00, k);
    `CHK("unsup", 2'b01, {k, evt_en})
    dset(8'h81, da, 8'h01, k);
    `CHK("dis", 2'b00, {evt_en, ibi_ok})
    bset(8'h00, 8'h01);
    `CHK("en bcast", 1'b1, evt_en)
    bset(8'h01, 8'h01);
    `CHK("dis bcast", 1'b0, evt_en)
    bset(8'h00, 8'h01);
    bset(8'h20, 8'h00);
    `CHK("hdr", 1'b1, evt_en)
  endtask
  task automatic t_err;
    logic k;
    ctl.start();
    send(8'hFD, k);
    ctl.wt(20);
    `CHK("ibi held", 2'b10, {evt_en, ibi_ok})
    ctl.start();
    send({da, 1'b0}, k);
    `CHK("err start", 1'b0, k)
    ctl.stop();
    `CHK("ibi back", 1'b1, ibi_ok)
    dset(8'h88, da, 8'h66, k);
    dset(8'h80, 7'h33, 8'h01, k);
    `CHK("newda", 1'b1, k)
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    da = 7'h21;
    do_reset();
    t_dasa();
    do_reset();
    da = 7'h2A;
    t_daa();
    t_wr();
    t_rd();
    t_ccc();
    t_err();
    end_of_test();
  end
endmodule
`default_nettype wire
